// ==== rtl/ice_debug_ctrl.sv ====
// emulator control: mapping, breakpoints, trace, stepping, command/status
`timescale 1ns/1ps
`default_nettype none
module ice_debug_ctrl #(
  parameter int unsigned HIST_DEPTH = ice_pkg::HIST_DEPTH,
  parameter int unsigned TICK_DIV   = ice_pkg::INT_TICK_DIV
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // target clock source
  input  wire logic              target_clk_tick,
  output logic                   emu_clk_tick,
  // host command and status
  input  wire logic              cmd_wr,
  input  wire logic [7:0]        cmd_data,
  output logic [7:0]             status_reg,
  // mapping and breakpoint configuration from control block
  input  wire ice_pkg::ice_map_type map_cfg,
  input  wire logic              bp_wr,
  input  wire logic              bp_sel,
  input  wire logic [23:0]       bp_data,
  // target bus cycle observation
  input  wire logic              cyc_valid,
  input  wire ice_pkg::ice_cycle_type cyc_info,
  input  wire ice_pkg::ice_kind_type  cyc_kind,
  input  wire logic              user_probe,
  // routing and run control
  output logic                   route_to_host,
  output logic                   target_run,
  // host bus mastership
  output logic                   bus_req,
  input  wire logic              bus_grant,
  output logic                   bus_master,
  // readback of halted state
  input  wire logic [5:0]        hist_age,
  output ice_pkg::ice_cycle_type hist_entry,
  output logic [31:0]            cycle_count
);
  initial begin
    if (TICK_DIV < 1) $error("clock divider must be at least one");
    if (TICK_DIV > 256) $error("clock divider wider than its counter");
    if (HIST_DEPTH < 2 || HIST_DEPTH > 64) $error("history depth out of range");
  end

  ice_pkg::ice_mode_type mode_reg;
  ice_pkg::ice_mode_type mode_next;
  logic [23:0] bp0_reg;
  logic [23:0] bp1_reg;
  logic [1:0]  hit_reg;
  logic        want_bus_reg;
  logic        master_reg;
  logic [31:0] count_reg;
  logic [7:0]  div_reg;
  logic        int_tick;
  logic        hist_wrap;

  // one comparator term; any selected cycle kind and all selected extra qualifiers must hold
  function automatic logic bp_match(input logic [23:0] bp,
                                    input ice_pkg::ice_cycle_type c,
                                    input ice_pkg::ice_kind_type k,
                                    input logic probe);
    logic kind_ok;
    logic ext_ok;
    kind_ok = (bp[ice_pkg::BQ_MRD] & k.mem_rd) | (bp[ice_pkg::BQ_MWR] & k.mem_wr) |
              (bp[ice_pkg::BQ_IORD] & k.io_rd) | (bp[ice_pkg::BQ_IOWR] & k.io_wr);
    ext_ok = (~bp[ice_pkg::BQ_STACK] | k.stack) &
             (~bp[ice_pkg::BQ_FETCH] | k.fetch) &
             (~bp[ice_pkg::BQ_USER] | probe);
    bp_match = bp[ice_pkg::BQ_EN] & kind_ok & ext_ok &
               (bp[15:0] == c.addr);
  endfunction : bp_match

  // internal 2 MHz tick or target clock
  assign int_tick     = (div_reg == 8'(TICK_DIV - 1));
  assign emu_clk_tick = map_cfg.user_clock ? target_clk_tick : int_tick;

  // address routing
  wire         is_io     = cyc_kind.io_rd | cyc_kind.io_wr;
  wire [3:0]   mem_seg   = cyc_info.addr[15:12];
  wire [3:0]   port_grp  = cyc_info.addr[7:4];
  wire         mem_host  = map_cfg.mem_host[mem_seg];
  wire         io_host   = cyc_kind.io_rd ? map_cfg.in_host[port_grp]
                                          : map_cfg.out_host[port_grp];
  assign route_to_host = is_io ? io_host : mem_host;

  wire       running  = (mode_reg != ice_pkg::ICE_INTERR);
  wire       hit0     = bp_match(bp0_reg, cyc_info, cyc_kind, user_probe);
  wire       hit1     = bp_match(bp1_reg, cyc_info, cyc_kind, user_probe);
  wire       bp_hit   = cyc_valid & running & (hit0 | hit1);
  wire       cmd_halt = cmd_wr & (cmd_data == ice_pkg::CMD_HALT);
  wire       step_end = cyc_valid & cyc_kind.last_cycle;
  wire       capture  = cyc_valid & running;

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      ice_pkg::ICE_INTERR: begin
        if (cmd_wr && cmd_data == ice_pkg::CMD_RUN) begin
          mode_next = ice_pkg::ICE_RUN;
        end else if (cmd_wr && cmd_data == ice_pkg::CMD_STEP) begin
          mode_next = ice_pkg::ICE_STEP;
        end else if (cmd_wr && cmd_data == ice_pkg::CMD_MSTEP) begin
          mode_next = ice_pkg::ICE_MSTEP;
        end
      end
      ice_pkg::ICE_RUN: begin
        if (bp_hit || cmd_halt) begin
          mode_next = ice_pkg::ICE_INTERR;
        end
      end
      ice_pkg::ICE_STEP: begin
        if (step_end || bp_hit || cmd_halt) begin
          mode_next = ice_pkg::ICE_INTERR;
        end
      end
      ice_pkg::ICE_MSTEP: begin
        if (bp_hit || cmd_halt) begin
          mode_next = ice_pkg::ICE_INTERR;
        end
      end
      default: begin
        mode_next = ice_pkg::ICE_INTERR;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_reg <= ice_pkg::ICE_INTERR;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // breakpoint registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bp0_reg <= 24'h000000;
      bp1_reg <= 24'h000000;
    end else if (bp_wr) begin
      if (bp_sel) begin
        bp1_reg <= bp_data;
      end else begin
        bp0_reg <= bp_data;
      end
    end
  end

  // latched hits, cleared when a new run starts; a new hit wins
  wire start_cmd = cmd_wr & (mode_reg == ice_pkg::ICE_INTERR) &
                   ((cmd_data == ice_pkg::CMD_RUN) | (cmd_data == ice_pkg::CMD_STEP) |
                    (cmd_data == ice_pkg::CMD_MSTEP));
  wire [1:0] hit_next = (start_cmd ? 2'b00 : hit_reg) |
                        ({2{capture}} & {hit1, hit0});
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hit_reg <= 2'b00;
    end else begin
      hit_reg <= hit_next;
    end
  end

  // internal clock divider and elapsed cycle count
  wire clr_cnt = cmd_wr & ((cmd_data == ice_pkg::CMD_CLR_CNT) | start_cmd &
                 (cmd_data == ice_pkg::CMD_RUN));
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_reg   <= 8'h00;
      count_reg <= 32'h00000000;
    end else begin
      div_reg <= int_tick ? 8'h00 : div_reg + 8'h01;
      if (clr_cnt) begin
        count_reg <= 32'h00000000;
      end else if (running && emu_clk_tick) begin
        count_reg <= count_reg + 32'h00000001;
      end
    end
  end

  // host bus mastership
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      want_bus_reg <= 1'b0;
      master_reg   <= 1'b0;
    end else begin
      if (cmd_wr && cmd_data == ice_pkg::CMD_TAKE_BUS) begin
        want_bus_reg <= 1'b1;
      end else if (cmd_wr && cmd_data == ice_pkg::CMD_FREE_BUS) begin
        want_bus_reg <= 1'b0;
      end
      master_reg <= want_bus_reg & bus_grant;
    end
  end
  assign bus_req    = want_bus_reg;
  assign bus_master = master_reg;

  ice_history #(
    .DEPTH(HIST_DEPTH)
  ) u_hist (
    .mclk     (mclk),
    .rst      (rst),
    .wr_en    (capture),
    .wr_entry (cyc_info),
    .rd_age   (hist_age),
    .rd_entry (hist_entry),
    .wrapped  (hist_wrap)
  );

  assign target_run  = running;
  assign cycle_count = count_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_reg <= ice_pkg::STATUS_RST;
    end else begin
      status_reg[ice_pkg::ST_EMUL]   <= (mode_next == ice_pkg::ICE_RUN);
      status_reg[ice_pkg::ST_INTERR] <= (mode_next == ice_pkg::ICE_INTERR);
      status_reg[ice_pkg::ST_BP0]    <= hit_next[0];
      status_reg[ice_pkg::ST_BP1]    <= hit_next[1];
      status_reg[ice_pkg::ST_STEP]   <= (mode_next == ice_pkg::ICE_STEP);
      status_reg[ice_pkg::ST_MSTEP]  <= (mode_next == ice_pkg::ICE_MSTEP);
      status_reg[ice_pkg::ST_MASTER] <= master_reg;
      status_reg[ice_pkg::ST_WRAP]   <= hist_wrap;
    end
  end
endmodule : ice_debug_ctrl
`default_nettype wire

// ==== rtl/ice_history.sv ====
// circular trace store of recent machine cycles
`timescale 1ns/1ps
`default_nettype none
module ice_history #(
  parameter int unsigned DEPTH = ice_pkg::HIST_DEPTH
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // capture side
  input  wire logic              wr_en,
  input  wire ice_pkg::ice_cycle_type wr_entry,
  // readback side, age 0 is newest
  input  wire logic [5:0]        rd_age,
  output ice_pkg::ice_cycle_type rd_entry,
  output logic                   wrapped
);
  initial begin
    if (DEPTH < 2 || DEPTH > 64) $error("history depth out of range");
  end

  ice_pkg::ice_cycle_type mem [DEPTH];
  logic [5:0] wp_reg;
  logic [5:0] wp_next;
  logic       wrap_reg;
  logic [5:0] rd_idx;
  logic [6:0] rd_sum;

  assign wp_next = (wp_reg == 6'(DEPTH - 1)) ? 6'h00 : wp_reg + 6'h01;
  assign rd_sum  = {1'b0, wp_reg} + 7'(DEPTH) - 7'h01 - {1'b0, rd_age};
  assign rd_idx  = (rd_sum >= 7'(DEPTH)) ? 6'(rd_sum - 7'(DEPTH)) : rd_sum[5:0];
  assign wrapped = wrap_reg;

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wp_reg] <= wr_entry;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_reg   <= 6'h00;
      wrap_reg <= 1'b0;
    end else if (wr_en) begin
      wp_reg   <= wp_next;
      wrap_reg <= wrap_reg | (wp_reg == 6'(DEPTH - 1));
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_entry <= '0;
    end else begin
      rd_entry <= mem[rd_idx];
    end
  end
endmodule : ice_history
`default_nettype wire

// ==== rtl/ice_pkg.sv ====
// constants and types for the in-circuit emulator debug control block
// Notes on behaviour
// - target memory served by host or target, chosen per 4K segment over 64K
// - target I/O ports mapped host or target per 16-port group, input/output separate
// - run from internal 2 MHz clock tick or target clock, chosen by configuration
// - route target accesses to host once assigned; all-host, all-target or mixed
// - two comparators break on matching cycle, qualified memory/io read/write
// - optional AND with stack, opcode fetch state, or user logic signal
// - breakpoint hit while emulating stops target and enters interrogation
// - keep address, data, status of last 44 machine cycles for reading
// - count clock cycles since program start, readable once halted
// - single step runs one instruction then halts
// - multi-step stores every cycle, continues; stops on break or command
// - host writes 8-bit command register; device acts on each write
// - 8-bit status register shows operating state to host
// - device requests and takes host bus as master when needed
// - two 24-bit breakpoint registers hold address and qualifiers
// - configuration and status also exchanged via control block in host memory
package ice_pkg;
  localparam int unsigned HIST_DEPTH   = 44;
  localparam int unsigned SEG_COUNT    = 16;
  localparam int unsigned PORT_GROUPS  = 16;
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned BP_W         = 24;
  localparam int unsigned CYC_W        = 32;
  localparam int unsigned MCLK_HZ      = 10000000;
  localparam int unsigned INT_CLK_HZ   = 2000000;
  localparam int unsigned INT_TICK_DIV = MCLK_HZ / INT_CLK_HZ;
  // command codes
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_RUN      = 8'h01;
  localparam logic [7:0] CMD_STEP     = 8'h02;
  localparam logic [7:0] CMD_MSTEP    = 8'h03;
  localparam logic [7:0] CMD_HALT     = 8'h04;
  localparam logic [7:0] CMD_CLR_CNT  = 8'h05;
  localparam logic [7:0] CMD_TAKE_BUS = 8'h06;
  localparam logic [7:0] CMD_FREE_BUS = 8'h07;
  // status bit positions
  localparam int unsigned ST_EMUL   = 0;
  localparam int unsigned ST_INTERR = 1;
  localparam int unsigned ST_BP0    = 2;
  localparam int unsigned ST_BP1    = 3;
  localparam int unsigned ST_STEP   = 4;
  localparam int unsigned ST_MSTEP  = 5;
  localparam int unsigned ST_MASTER = 6;
  localparam int unsigned ST_WRAP   = 7;
  // breakpoint register qualifier bit positions (above 16 address bits)
  localparam int unsigned BQ_MRD   = 16;
  localparam int unsigned BQ_MWR   = 17;
  localparam int unsigned BQ_IORD  = 18;
  localparam int unsigned BQ_IOWR  = 19;
  localparam int unsigned BQ_STACK = 20;
  localparam int unsigned BQ_FETCH = 21;
  localparam int unsigned BQ_USER  = 22;
  localparam int unsigned BQ_EN    = 23;
  localparam logic [7:0] STATUS_RST = 8'h02;

  typedef enum {
    ICE_INTERR,
    ICE_RUN,
    ICE_STEP,
    ICE_MSTEP
  } ice_mode_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
    logic [7:0]        status;
  } ice_cycle_type;

  typedef struct packed {
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
    logic stack;
    logic fetch;
    logic last_cycle;
  } ice_kind_type;

  typedef struct packed {
    logic [SEG_COUNT-1:0]   mem_host;
    logic [PORT_GROUPS-1:0] in_host;
    logic [PORT_GROUPS-1:0] out_host;
    logic                   user_clock;
  } ice_map_type;
endpackage : ice_pkg

// ==== testbench/ice_ctrl_properties.sv ====
// port checker for the emulator debug control block
`timescale 1ns/1ps
`default_nettype none
module ice_ctrl_props (
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   rst,
  // command and status
  input wire logic                   cmd_wr,
  input wire logic [7:0]             cmd_data,
  input wire logic [7:0]             status_reg,
  input wire logic                   target_run,
  input wire logic [31:0]            cycle_count,
  // mapping and cycles
  input wire ice_pkg::ice_map_type   map_cfg,
  input wire logic                   cyc_valid,
  input wire ice_pkg::ice_cycle_type cyc_info,
  input wire ice_pkg::ice_kind_type  cyc_kind,
  input wire logic                   route_to_host,
  // clocks and bus
  input wire logic                   target_clk_tick,
  input wire logic                   emu_clk_tick,
  input wire logic                   bus_req,
  input wire logic                   bus_grant,
  input wire logic                   bus_master
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic [3:0] seg = cyc_info.addr[15:12];
  wire logic [3:0] grp = cyc_info.addr[7:4];
  sequence start_s;
    cmd_wr && cmd_data == ice_pkg::CMD_RUN && !target_run;
  endsequence
  sequence halt_s;
    cmd_wr && cmd_data == ice_pkg::CMD_HALT && target_run;
  endsequence
  run_start_a: assert property (start_s |=> target_run && cycle_count == 32'h0)
    else $error("run command did not start emulation");
  halt_cmd_a: assert property (halt_s |=> !target_run && status_reg[ice_pkg::ST_INTERR])
    else $error("halt command did not stop emulation");
  mode_flag_a: assert property (status_reg[ice_pkg::ST_INTERR] == !target_run)
    else $error("status mode bit disagrees with run output");
  mem_route_a: assert property (cyc_valid && (cyc_kind.mem_rd || cyc_kind.mem_wr)
    |-> route_to_host == map_cfg.mem_host[seg]) else $error("memory route wrong");
  in_route_a: assert property (cyc_valid && cyc_kind.io_rd
    |-> route_to_host == map_cfg.in_host[grp]) else $error("input port route wrong");
  out_route_a: assert property (cyc_valid && cyc_kind.io_wr
    |-> route_to_host == map_cfg.out_host[grp]) else $error("output port route wrong");
  bus_grant_a: assert property (bus_req && bus_grant |=> bus_master)
    else $error("grant not turned into mastership");
  bus_free_a: assert property (!bus_req |=> !bus_master)
    else $error("mastership without request");
  user_tick_a: assert property (map_cfg.user_clock |-> emu_clk_tick == target_clk_tick)
    else $error("user clock not followed");
  int_tick_a: assert property (emu_clk_tick && !map_cfg.user_clock |=> (!emu_clk_tick) [*4])
    else $error("internal tick too early");
  count_hold_a: assert property (!target_run && !cmd_wr |=> $stable(cycle_count))
    else $error("cycle count moved while halted");
endmodule : ice_ctrl_props
bind ice_debug_ctrl ice_ctrl_props u_props (.mclk(mclk), .rst(rst), .cmd_wr(cmd_wr),
  .cmd_data(cmd_data), .status_reg(status_reg), .target_run(target_run),
  .cycle_count(cycle_count), .map_cfg(map_cfg), .cyc_valid(cyc_valid), .cyc_info(cyc_info),
  .cyc_kind(cyc_kind), .route_to_host(route_to_host), .target_clk_tick(target_clk_tick),
  .emu_clk_tick(emu_clk_tick), .bus_req(bus_req), .bus_grant(bus_grant),
  .bus_master(bus_master));
`default_nettype wire

// ==== testbench/ice_target_model.sv ====
// target system cycles, target clock and host bus arbiter model
`timescale 1ns/1ps
`default_nettype none
module ice_target_model (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // requests from the bench
  input  wire logic                  go,
  input  wire logic [15:0]           addr,
  input  wire ice_pkg::ice_kind_type kind,
  input  wire logic                  tick_en,
  input  wire logic                  slow,
  // to and from the block
  input  wire logic                  bus_req,
  output var ice_pkg::ice_cycle_type cyc_info,
  output var ice_pkg::ice_kind_type  cyc_kind,
  output var logic                   cyc_valid,
  output var logic                   target_clk_tick,
  output var logic                   bus_grant
);
  logic [1:0] tick_reg;
  logic [1:0] wait_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cyc_valid <= 1'b0;
      cyc_info <= '0;
      cyc_kind <= '0;
      target_clk_tick <= 1'b0;
      bus_grant <= 1'b0;
      tick_reg <= 2'h0;
      wait_reg <= 2'h0;
    end else begin
      cyc_valid <= go;
      cyc_kind <= go ? kind : '0;
      // released bus toggles between the last value and its complement
      cyc_info <= go ? {addr, addr[7:0] ^ 8'h5a, 8'ha2} : ~cyc_info;
      tick_reg <= (tick_reg == 2'h2) ? 2'h0 : tick_reg + 2'h1;
      target_clk_tick <= tick_en && tick_reg == 2'h0;
      wait_reg <= bus_req ? wait_reg + {1'b0, wait_reg != 2'h3} : 2'h0;
      bus_grant <= bus_req && (!slow || wait_reg == 2'h3);
    end
  end
endmodule : ice_target_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the emulator debug control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                   mclk, rst, cmd_wr, bp_wr, bp_sel, user_probe, go, tick_en, slow;
  logic                   emu_clk_tick, route_to_host, target_run, bus_req, bus_master;
  logic                   target_clk_tick, bus_grant, cyc_valid, h, rt;
  logic [7:0]             cmd_data, status_reg;
  logic [23:0]            bp_data, d;
  logic [15:0]            addr, a;
  logic [5:0]             hist_age;
  logic [31:0]            cycle_count, cnt;
  logic [63:0]            rv;
  ice_pkg::ice_kind_type  kind, k;
  ice_pkg::ice_map_type   map_cfg;
  ice_pkg::ice_cycle_type cyc_info, hist_entry;
  int                     miscompares, num_checks, seed, i;
  ice_debug_ctrl DUT (.mclk(mclk), .rst(rst), .target_clk_tick(target_clk_tick),
    .emu_clk_tick(emu_clk_tick), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
    .status_reg(status_reg), .map_cfg(map_cfg), .bp_wr(bp_wr), .bp_sel(bp_sel),
    .bp_data(bp_data), .cyc_valid(cyc_valid), .cyc_info(cyc_info), .cyc_kind(k),
    .user_probe(user_probe), .route_to_host(route_to_host), .target_run(target_run),
    .bus_req(bus_req), .bus_grant(bus_grant), .bus_master(bus_master),
    .hist_age(hist_age), .hist_entry(hist_entry), .cycle_count(cycle_count));
  ice_target_model u_far (.mclk(mclk), .rst(rst), .go(go), .addr(addr), .kind(kind),
    .tick_en(tick_en), .slow(slow), .bus_req(bus_req), .cyc_info(cyc_info),
    .cyc_kind(k), .cyc_valid(cyc_valid), .target_clk_tick(target_clk_tick),
    .bus_grant(bus_grant));
  function automatic ice_pkg::ice_kind_type kind_of(int j);
    return ice_pkg::ice_kind_type'(7'h40 >> j);
  endfunction : kind_of
  function automatic logic route_exp(logic [15:0] x, ice_pkg::ice_kind_type q);
    if (q.io_rd) return map_cfg.in_host[x[7:4]];
    if (q.io_wr) return map_cfg.out_host[x[7:4]];
    return map_cfg.mem_host[x[15:12]];
  endfunction : route_exp
  function automatic logic hit_exp(logic [23:0] b, logic [15:0] x, ice_pkg::ice_kind_type q);
    logic any;
    any = (b[16] & q.mem_rd) | (b[17] & q.mem_wr) | (b[18] & q.io_rd) | (b[19] & q.io_wr);
    return b[23] && b[15:0] == x && any && (!b[20] || q.stack) && (!b[21] || q.fetch)
      && (!b[22] || user_probe);
  endfunction : hit_exp
  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic cmd(logic [7:0] c);
    @(posedge mclk);
    cmd_wr <= 1'b1;
    cmd_data <= c;
    @(posedge mclk);
    cmd_wr <= 1'b0;
    #1;
  endtask : cmd
  task automatic setbp(logic s, logic [23:0] v);
    @(posedge mclk);
    bp_wr <= 1'b1;
    bp_sel <= s;
    bp_data <= v;
    @(posedge mclk);
    bp_wr <= 1'b0;
  endtask : setbp
  task automatic cyc(logic [15:0] x, ice_pkg::ice_kind_type q);
    @(posedge mclk);
    go <= 1'b1;
    addr <= x;
    kind <= q;
    @(posedge mclk);
    go <= 1'b0;
    #1;
    rt = route_to_host;
    @(posedge mclk);
    #1;
  endtask : cyc
  task automatic finish_test;
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    seed = 32'hfb405f14;
    {rst, cmd_wr, bp_wr, bp_sel, user_probe, go, tick_en, slow} = 8'h80;
    {cmd_data, bp_data, addr, hist_age, kind, map_cfg} = '0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("status", ice_pkg::STATUS_RST, status_reg);
    chk("run", 0, target_run);
    cmd(8'h5c);
    chk("status", ice_pkg::STATUS_RST, status_reg);
    for (i = 0; i < 24; i++) begin
      rv = (i < 2) ? {64{i == 0}} : {$random(seed), $random(seed)};
      map_cfg <= rv[48:0] & ~49'h1;
      a = 16'($random(seed));
      cyc(a, kind_of(i % 4));
      chk("route", route_exp(a, kind_of(i % 4)), rt);
    end
    for (i = 0; i < 16; i++) begin
      d = 24'($random(seed));
      d[23] = (i != 5);
      a = i[1] ? d[15:0] : 16'($random(seed));
      kind = kind_of(i % 4) | 7'($random(seed) & 6);
      if (i < 4) d = {8'h80 | (8'h01 << i), a};
      user_probe <= 1'($random(seed));
      setbp(i[0], d);
      setbp(!i[0], 24'h0);
      cmd(ice_pkg::CMD_RUN);
      chk("run", 1, target_run);
      cyc(a, i < 4 ? kind_of(i) : kind);
      h = hit_exp(d, a, i < 4 ? kind_of(i) : kind);
      chk("halt", !h, target_run);
      chk("hit", h, status_reg[ice_pkg::ST_BP0 + i[0]]);
      if (!h) cmd(ice_pkg::CMD_HALT);
    end
    cmd(ice_pkg::CMD_RUN);
    chk("emul", 1, status_reg[ice_pkg::ST_EMUL]);
    repeat (50) @(posedge mclk);
    cmd(ice_pkg::CMD_HALT);
    cnt = cycle_count;
    chk("count", 1, cnt >= 10 && cnt <= 11);
    cmd(ice_pkg::CMD_CLR_CNT);
    chk("count", 0, cycle_count);
    setbp(1'b1, 24'h0);
    cmd(ice_pkg::CMD_STEP);
    chk("step", 1, status_reg[ice_pkg::ST_STEP]);
    cyc(16'h0100, 7'h42);
    chk("step", 1, target_run);
    cyc(16'h0101, 7'h41);
    chk("step", 0, target_run);
    cmd(ice_pkg::CMD_MSTEP);
    for (i = 0; i < 46; i++) cyc(16'(i * 16'h0105), 7'h41);
    chk("mstep", 1, target_run);
    chk("mstep", 1, status_reg[ice_pkg::ST_MSTEP]);
    cmd(ice_pkg::CMD_HALT);
    chk("wrap", 1, status_reg[ice_pkg::ST_WRAP]);
    for (i = 0; i < 44; i += 21) begin
      @(posedge mclk);
      hist_age <= 6'(i + (i == 42));
      @(posedge mclk);
      @(posedge mclk);
      #1;
      a = 16'((45 - i - (i == 42)) * 16'h0105);
      chk("trace", {a, a[7:0] ^ 8'h5a, 8'ha2}, hist_entry);
    end
    map_cfg.user_clock <= 1'b1;
    repeat (6) @(posedge mclk);
    tick_en <= 1'b1;
    for (i = 0; i < 12; i++) begin
      @(posedge mclk);
      #1;
      chk("tick", target_clk_tick, emu_clk_tick);
    end
    tick_en <= 1'b0;
    slow <= 1'b1;
    cmd(ice_pkg::CMD_TAKE_BUS);
    chk("req", 1, bus_req);
    for (i = 0; i < 20 && bus_master !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("master", 1, bus_master);
    if (bus_master !== 1'b1) finish_test();
    @(posedge mclk);
    #1;
    chk("master", 1, status_reg[ice_pkg::ST_MASTER]);
    cmd(ice_pkg::CMD_FREE_BUS);
    repeat (3) @(posedge mclk);
    #1;
    chk("master", 0, bus_master);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
